// *** inc/nbt_regs.vh ***
`ifndef NBT_REGS_VH
`define NBT_REGS_VH
`define NBT_CMD_READ1     8'h00
`define NBT_CMD_READ2     8'h30
`define NBT_CMD_RDCACHE   8'h31
`define NBT_CMD_RDLAST    8'h3F
`define NBT_CMD_COPYRD    8'h3A
`define NBT_CMD_LOAD      8'h80
`define NBT_CMD_LOADM     8'h81
`define NBT_CMD_PROG      8'h10
`define NBT_CMD_MPROG     8'h11
`define NBT_CMD_CACHE     8'h15
`define NBT_CMD_STATUS    8'h70
`define NBT_CMD_RESET     8'hFF
`define NBT_STAT_READY    6
`define NBT_MAX_PARTIAL   3'h4
// Counts are core_clk cycles at 200 MHz, sized to the phase counter.
`define NBT_STROBE_CYC    5'h03
// Busy may appear up to 100 ns after the strobe rises, then needs two synchroniser stages.
`define NBT_WB_CYC        5'h16
// Ready to the next read strobe is at least 20 ns.
`define NBT_RR_CYC        5'h04
`define NBT_OP_IDLE       3'h0
`define NBT_OP_CMD        3'h1
`define NBT_OP_ADDR       3'h2
`define NBT_OP_WDATA      3'h3
`define NBT_OP_RDATA      3'h4
`define NBT_OP_WAITRDY    3'h5
`define NBT_OP_STATUS     3'h6
`endif

// *** hdl/nbt_host.v ***
`default_nettype none
`include "nbt_regs.vh"
module nbt_host (
   input  wire       core_clk,
   input  wire       rst_n,
   input  wire       op_valid,
   input  wire [2:0] op_kind,
   input  wire [7:0] op_byte,
   output reg        op_ready,
   output reg        rd_valid,
   output reg  [7:0] rd_byte,
   output reg        cache_end_15,
   output reg        partial_err,
   output reg        cmd_latch,
   output reg        addr_latch,
   output reg        chip_sel_n,
   output reg        write_strobe_n,
   output reg        read_strobe_n,
   input  wire [7:0] io_in,
   output reg  [7:0] io_out,
   output reg        io_oe_n,
   input  wire       ready_busy_out
);
   localparam ST_IDLE  = 3'h0;
   localparam ST_WLOW  = 3'h1;
   localparam ST_WHIGH = 3'h2;
   localparam ST_RLOW  = 3'h3;
   localparam ST_RHIGH = 3'h4;
   localparam ST_WB    = 3'h5;
   localparam ST_POLL  = 3'h6;

   reg [2:0] state_reg;
   reg [4:0] cnt_reg;
   reg [2:0] kind_reg;
   reg [7:0] last_cmd_reg;
   reg [2:0] partial_reg;
   reg       rb_meta_reg;
   reg       rb_sync_reg;
   reg [7:0] io_meta_reg;
   reg [7:0] io_sync_reg;

   function is_busy_cmd;
      input [7:0] c;
      begin
         is_busy_cmd = (c == `NBT_CMD_READ2) || (c == `NBT_CMD_RDCACHE) || (c == `NBT_CMD_RDLAST) ||
                       (c == `NBT_CMD_COPYRD) || (c == `NBT_CMD_PROG) || (c == `NBT_CMD_MPROG) ||
                       (c == `NBT_CMD_CACHE) || (c == `NBT_CMD_RESET);
      end
   endfunction

   function is_any_time_cmd;
      input [7:0] c;
      begin
         is_any_time_cmd = (c == `NBT_CMD_RESET) || (c == `NBT_CMD_STATUS);
      end
   endfunction

   wire ready_now = rb_sync_reg;
   wire take = op_valid && op_ready;

   always @(posedge core_clk) begin
      if (!rst_n) begin
         rb_meta_reg <= 1'b0;
         rb_sync_reg <= 1'b0;
         io_meta_reg <= 8'h00;
         io_sync_reg <= 8'h00;
      end else begin
         rb_meta_reg <= ready_busy_out;
         rb_sync_reg <= rb_meta_reg;
         io_meta_reg <= io_in;
         io_sync_reg <= io_meta_reg;
      end
   end

   always @(posedge core_clk) begin
      if (!rst_n) begin
         state_reg      <= ST_IDLE;
         cnt_reg        <= 5'h00;
         kind_reg       <= `NBT_OP_IDLE;
         last_cmd_reg   <= `NBT_CMD_RESET;
         partial_reg    <= 3'h0;
         op_ready       <= 1'b0;
         rd_valid       <= 1'b0;
         rd_byte        <= 8'h00;
         cache_end_15   <= 1'b0;
         partial_err    <= 1'b0;
         cmd_latch      <= 1'b0;
         addr_latch     <= 1'b0;
         chip_sel_n     <= 1'b1;
         write_strobe_n <= 1'b1;
         read_strobe_n  <= 1'b1;
         io_out         <= 8'h00;
         io_oe_n        <= 1'b1;
      end else begin
         rd_valid <= 1'b0;
         case (state_reg)
            ST_IDLE: begin
               // Ready is only offered while the device is ready with no 15h end pending, or on alternate cycles after a 15h end.
               op_ready <= ready_now && !cache_end_15;
               if (cache_end_15 && !op_ready) begin
                  op_ready <= 1'b1;
               end
               if (take) begin
                  op_ready <= 1'b0;
                  kind_reg <= op_kind;
                  chip_sel_n <= 1'b0;
                  cnt_reg <= `NBT_STROBE_CYC;
                  if (op_kind == `NBT_OP_RDATA || op_kind == `NBT_OP_STATUS) begin
                     io_oe_n <= 1'b1;
                     read_strobe_n <= 1'b0;
                     state_reg <= ST_RLOW;
                  end else if (op_kind == `NBT_OP_WAITRDY) begin
                     state_reg <= ST_POLL;
                  end else if (cache_end_15 && !(op_kind == `NBT_OP_CMD && is_any_time_cmd(op_byte))) begin
                     // After a 15h end only reads, ready waits and the status and reset commands are accepted.
                     partial_err <= 1'b1;
                     chip_sel_n <= 1'b1;
                     state_reg <= ST_IDLE;
                  end else begin
                     cmd_latch <= (op_kind == `NBT_OP_CMD);
                     addr_latch <= (op_kind == `NBT_OP_ADDR);
                     io_out <= op_byte;
                     io_oe_n <= 1'b0;
                     write_strobe_n <= 1'b0;
                     state_reg <= ST_WLOW;
                     if (op_kind == `NBT_OP_CMD) begin
                        last_cmd_reg <= op_byte;
                        if (op_byte == `NBT_CMD_CACHE && last_cmd_reg != `NBT_CMD_LOADM) begin
                           cache_end_15 <= 1'b1;
                        end
                        if (op_byte == `NBT_CMD_RESET) begin
                           cache_end_15 <= 1'b0;
                           partial_reg <= 3'h0;
                        end
                        if (op_byte == `NBT_CMD_PROG || op_byte == `NBT_CMD_CACHE || op_byte == `NBT_CMD_MPROG) begin
                           if (partial_reg == `NBT_MAX_PARTIAL) begin
                              partial_err <= 1'b1;
                           end else begin
                              partial_reg <= partial_reg + 3'h1;
                           end
                        end
                        if (op_byte == `NBT_CMD_READ1 || op_byte == `NBT_CMD_LOAD) begin
                           partial_err <= 1'b0;
                        end
                     end
                  end
               end
            end
            ST_WLOW: begin
               if (cnt_reg == 5'h00) begin
                  write_strobe_n <= 1'b1;
                  cnt_reg <= `NBT_STROBE_CYC;
                  state_reg <= ST_WHIGH;
               end else begin
                  cnt_reg <= cnt_reg - 5'h01;
               end
            end
            ST_WHIGH: begin
               if (cnt_reg == 5'h00) begin
                  cmd_latch <= 1'b0;
                  addr_latch <= 1'b0;
                  io_oe_n <= 1'b1;
                  if (kind_reg == `NBT_OP_CMD && is_busy_cmd(last_cmd_reg)) begin
                     // Busy may take up to the falling-edge delay to appear on the pin.
                     cnt_reg <= `NBT_WB_CYC;
                     state_reg <= ST_WB;
                  end else begin
                     state_reg <= ST_IDLE;
                  end
               end else begin
                  cnt_reg <= cnt_reg - 5'h01;
               end
            end
            ST_RLOW: begin
               if (cnt_reg == 5'h00) begin
                  // Sample late in the low phase; long high phase gives normal output release.
                  rd_byte <= io_sync_reg;
                  rd_valid <= 1'b1;
                  read_strobe_n <= 1'b1;
                  cnt_reg <= `NBT_STROBE_CYC;
                  state_reg <= ST_RHIGH;
               end else begin
                  cnt_reg <= cnt_reg - 5'h01;
               end
            end
            ST_RHIGH: begin
               if (cnt_reg == 5'h00) begin
                  state_reg <= ST_IDLE;
               end else begin
                  cnt_reg <= cnt_reg - 5'h01;
               end
            end
            ST_WB: begin
               if (cnt_reg == 5'h00) begin
                  state_reg <= ST_POLL;
               end else begin
                  cnt_reg <= cnt_reg - 5'h01;
               end
            end
            ST_POLL: begin
               // No timeout: the device bounds its own busy time.
               if (ready_now) begin
                  cnt_reg <= `NBT_RR_CYC;
                  state_reg <= ST_RHIGH;
               end
            end
            default: begin
               state_reg <= ST_IDLE;
            end
         endcase
         if (state_reg != ST_IDLE && state_reg != ST_POLL && state_reg != ST_WB) begin
            chip_sel_n <= 1'b0;
         end
         if (kind_reg == `NBT_OP_STATUS && rd_valid && rd_byte[`NBT_STAT_READY]) begin
            partial_reg <= partial_reg;
         end
      end
   end
endmodule // nbt_host
`default_nettype wire

// *** test/nbt_host_monitor.sv ***
`default_nettype none
module nbt_host_monitor (
   input wire logic       core_clk, rst_n, op_valid, op_ready, rd_valid, cache_end_15, partial_err,
   input wire logic       cmd_latch, addr_latch, chip_sel_n, write_strobe_n, read_strobe_n,
   input wire logic       io_oe_n, ready_busy_out,
   input wire logic [2:0] op_kind,
   input wire logic [7:0] op_byte, rd_byte, io_in, io_out
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   a_no_host_drive: assert property (!read_strobe_n |-> io_oe_n)
      else $error("host drives bus in read");
   a_busy_blocks_op: assert property (!ready_busy_out [*4] |-> !op_ready)
      else $error("request taken while busy");
   a_strobes_apart: assert property (write_strobe_n || read_strobe_n)
      else $error("both strobes low");
   a_latches_apart: assert property (!(cmd_latch && addr_latch))
      else $error("both latches high");
   a_read_byte_due: assert property ($fell(read_strobe_n) |-> ##4 rd_valid)
      else $error("read byte late");
   a_write_width: assert property ($fell(write_strobe_n) |-> !write_strobe_n [*4] ##1 write_strobe_n)
      else $error("write strobe width");
   a_write_drives: assert property (!write_strobe_n |-> !io_oe_n)
      else $error("write without bus drive");
   a_chip_selected: assert property ((!write_strobe_n || !read_strobe_n) |-> !chip_sel_n)
      else $error("strobe without chip select");
   cover property (rd_valid);
   cover property ($rose(cache_end_15));
   cover property ($rose(partial_err));
endmodule // nbt_host_monitor
bind nbt_host nbt_host_monitor mon (.*);
`default_nettype wire

// *** test/nbt_dev_model.sv ***
`default_nettype none
module nbt_dev_model (
   input wire logic        cmd_latch, chip_sel_n, write_strobe_n, read_strobe_n, io_oe_n,
   input wire logic  [7:0] io_out,
   output wire logic [7:0] io_in,
   output var logic        ready_busy_out
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] q = 8'h00, col = 8'h00, cmd = 8'h00;
   logic       drv = 1'b0;
   // Busy spans are the maxima scaled down a hundredfold to keep the run short.
   function automatic int busy_ns(input logic [7:0] c);
      case (c)
         8'h30, 8'h31, 8'h3F: return 250;
         8'h3A: return 300;
         8'h11: return 100;
         8'h10, 8'h15: return 7000;
         8'hFF: return 50;
         default: return 0;
      endcase
   endfunction
   initial ready_busy_out = 1'b1;
   // A released bus shows the inverse of its last byte so stale data never matches.
   assign io_in = !io_oe_n ? io_out : drv ? q : ~q;
   always @(posedge write_strobe_n) if (cmd_latch && !chip_sel_n) begin
      cmd = io_out;
      if (cmd == 8'h00) col = 8'h00;
      if (busy_ns(cmd) > 0) begin
         #50 ready_busy_out = 1'b0;
         #(busy_ns(cmd)) ready_busy_out = 1'b1;
      end
   end
   always @(negedge read_strobe_n) begin
      #4 q = (cmd == 8'h70) ? {1'b0, ready_busy_out, 6'h00} : 8'hA0 + col;
      drv = 1'b1;
      if (cmd != 8'h70) col = col + 8'h01;
   end
   always @(posedge read_strobe_n) #3 drv = 1'b0;
endmodule // nbt_dev_model
`default_nettype wire

// *** test/nbt_host_test.sv ***
`default_nettype none
module nbt_host_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic       core_clk = 1'b0, rst_n = 1'b0, op_valid = 1'b0;
   logic [2:0] op_kind = 3'h0;
   logic [7:0] op_byte = 8'h00;
   wire        op_ready, rd_valid, cache_end_15, partial_err, cmd_latch, addr_latch;
   wire        chip_sel_n, write_strobe_n, read_strobe_n, io_oe_n, ready_busy_out;
   wire  [7:0] rd_byte, io_in, io_out;
   int         n_mismatch = 0, cmp_count = 0;
   always #2.5 core_clk = ~core_clk;
   nbt_host dut (.*);
   nbt_dev_model dev (.*);
   task automatic final_report();
      if (n_mismatch == 0 && cmp_count > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      cmp_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic idle();
      int i;
      i = 0;
      do begin
         @(negedge core_clk);
         i++;
      end while (op_ready !== 1'b1 && i < 4000);
      if (i >= 4000) n_mismatch++;
   endtask
   task automatic op(input logic [2:0] k, input logic [7:0] b);
      @(posedge core_clk);
      op_kind <= k;
      op_byte <= b;
      op_valid <= 1'b1;
      idle();
      @(posedge core_clk);
      op_valid <= 1'b0;
   endtask
   task automatic rd(input logic [2:0] k, input logic [7:0] exp, input string what);
      int i;
      op(k, 8'h00);
      i = 0;
      do begin
         @(negedge core_clk);
         i++;
      end while (rd_valid !== 1'b1 && i < 20);
      chk(what, exp, rd_byte);
   endtask
   task automatic t_read();
      op(3'h1, 8'h00);
      repeat (5) op(3'h2, 8'h00);
      op(3'h1, 8'h30);
      rd(3'h4, 8'hA0, "byte0");
      rd(3'h4, 8'hA1, "byte1");
      op(3'h1, 8'h70);
      rd(3'h6, 8'h40, "status");
   endtask
   task automatic t_copy();
      op(3'h1, 8'h00);
      repeat (5) op(3'h2, 8'h00);
      op(3'h1, 8'h3A);
      op(3'h5, 8'h00);
      rd(3'h4, 8'hA0, "copy");
      op(3'h1, 8'h31);
      rd(3'h4, 8'hA1, "cache");
      op(3'h1, 8'h3F);
      rd(3'h4, 8'hA2, "last");
   endtask
   task automatic t_cache();
      op(3'h1, 8'h80);
      repeat (5) op(3'h2, 8'h00);
      op(3'h3, 8'h5A);
      op(3'h1, 8'h15);
      idle();
      chk("end15", 8'h01, {7'h00, cache_end_15});
      op(3'h1, 8'h00);
      idle();
      chk("err", 8'h01, {7'h00, partial_err});
      op(3'h1, 8'h70);
      rd(3'h6, 8'h40, "poll");
      op(3'h1, 8'hFF);
      idle();
      chk("end15", 8'h00, {7'h00, cache_end_15});
      op(3'h1, 8'h80);
      idle();
      chk("err", 8'h00, {7'h00, partial_err});
      op(3'h3, 8'hA5);
      op(3'h1, 8'h10);
   endtask
   task automatic t_partial();
      op(3'h1, 8'hFF);
      op(3'h1, 8'h80);
      repeat (4) op(3'h1, 8'h10);
      idle();
      chk("err4", 8'h00, {7'h00, partial_err});
      op(3'h1, 8'h10);
      idle();
      chk("err5", 8'h01, {7'h00, partial_err});
   endtask
   initial begin
      repeat (8) @(posedge core_clk);
      rst_n <= 1'b1;
      t_read();
      t_copy();
      t_cache();
      t_partial();
      final_report();
   end
   initial begin
      #200000;
      n_mismatch++;
      final_report();
   end
endmodule // nbt_host_test
`default_nettype wire
